// ==== arc_regs.svh ====
// register offsets, field positions, reset values and timing counts for the converter control
// Summary of operation
// [R1] valid flag bit 17 sets on conversion done, clears on result read
// [R2] overrun flag bit 16 sets when unread result is overwritten, clears on read
// [R3] valid and overrun flags work only while the fifo is disabled
// [R4] no shift, no bias: result is plain 12-bit value from direct path or fifo
// [R5] bias on, shift off: 12-bit value low, bits 12 to 15 carry sign
// [R6] shift on: 16-bit value; with bias, 15-bit value with sign at bit 15
// [R7] no bias: four zeros above sample, or four zeros below when shifted
// [R8] bias: sign replicated four times, or sign, value, three zeros when shifted
// [R9] 12-bit bias field at control 27:16, reset 0x800, used for subtraction
// [R10] start bit 11 set by software or trigger, cleared on conversion done
// [R11] start bit low means converter idle; writing one begins a conversion
// [R12] control bit 10 picks dma request at fifo half full or full
// [R13] control bit 9 enables the result fifo
// [R14] hardware trigger enable bit 8 lets selected source set start bit
// [R15] bit 6 picks pin edge; level must hold four clocks high and low
// [R16] bits 5:4 select source: 00 pin, 11 pwm, others reserved
// [R17] software clears trigger enable and start before changing source
// [R18] bit 1 enables conversion-end interrupt request
// [R19] software sets converter enable bit 0 before converting, clears to power down
// [R20] conversion end sets end flag; software clears it to drop interrupt
// [R21] trigger pin deglitched by 3-bit counter, short pulses ignored
// [R22] reserved bits read zero and writes to them do nothing
`ifndef ARC_REGS_SVH
`define ARC_REGS_SVH
`define ARC_OFS_RESULT 12'h000
`define ARC_OFS_CTRL 12'h020
`define ARC_OFS_STATUS 12'h030
`define ARC_CTRL_RESET 32'h08000000
`define ARC_CTRL_MASK 32'h0FFF3F73
`define ARC_BIT_VALID 17
`define ARC_BIT_OVR 16
`define ARC_BIT_SUB 13
`define ARC_BIT_LSH 12
`define ARC_BIT_START 11
`define ARC_BIT_FULLSEL 10
`define ARC_BIT_FIFO 9
`define ARC_BIT_HWEN 8
`define ARC_BIT_EDGE 6
`define ARC_SRC_HI 5
`define ARC_SRC_LO 4
`define ARC_BIT_IEN 1
`define ARC_BIT_PWR 0
`define ARC_BIAS_HI 27
`define ARC_BIAS_LO 16
`define ARC_SRC_PIN 2'h0
`define ARC_SRC_PWM 2'h3
`define ARC_BIT_ENDF 0
`define ARC_STABLE_CLKS 3'h4
`define ARC_FIFO_DEPTH 16
`define ARC_FIFO_HALF 5'h08
`define ARC_FIFO_FULL 5'h10
`endif

// ==== arc_pkg.sv ====
// types shared by the converter control block
package arc_pkg;
    typedef struct packed {
        logic [11:0] sample;
        logic done;
    } arc_conv_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } arc_apb_req_t;
    typedef enum logic [1:0] {ARC_IDLE, ARC_BUSY, ARC_WAIT} arc_state_t;
endpackage

// ==== arc_control.sv ====
// converter control and result registers behind an apb slave
`timescale 1ns/1ps
`include "arc_regs.svh"
module arc_control (
    input wire logic mclk,
    input wire logic rst_n,
    input wire arc_pkg::arc_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire arc_pkg::arc_conv_t convIn,
    input wire logic externalTriggerPin,
    input wire logic pwmTrigger,
    input wire logic fifoPop,
    output logic convStart,
    output logic converterPowerEnable,
    output logic conversionIrq,
    output logic dmaReq
);
    import arc_pkg::*;

    logic [31:0] ctrl_ff;
    logic [11:0] direct_ff;
    logic valid_ff;
    logic ovr_ff;
    logic endFlag_ff;
    logic [11:0] fifoMem_ff [0:`ARC_FIFO_DEPTH-1];
    logic [3:0] wrPtr_ff;
    logic [3:0] rdPtr_ff;
    logic [4:0] count_ff;
    logic [1:0] pinSync_ff;
    logic [2:0] stableCnt_ff;
    logic pinLevel_ff;
    logic pwmPrev_ff;
    arc_state_t state_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic convStart_ff;
    logic irq_ff;
    logic dma_ff;

    logic wrAcc;
    logic rdAcc;
    logic rdResult;
    logic fifoOn;
    logic hwTrig;
    logic pinEdge;
    logic pinStable;
    logic fifoWr;
    logic fifoRd;
    logic [11:0] rawSample;
    logic [12:0] diff;
    logic [15:0] formatted;
    logic [31:0] nxt_prdata;

    ////////////////////////////////////////////////////////////////
    // bus decode: access taken in the first access cycle, pready answers one cycle later
    assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite && !pready_ff;
    assign rdAcc = apbReq.psel && apbReq.penable && !apbReq.pwrite && !pready_ff;
    assign rdResult = rdAcc && (apbReq.paddr == `ARC_OFS_RESULT);
    assign fifoOn = ctrl_ff[`ARC_BIT_FIFO];

    ////////////////////////////////////////////////////////////////
    // trigger pin: two-flop sync, then a 3-bit stability counter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pinSync_ff <= 2'h3;
        end else begin
            pinSync_ff <= {pinSync_ff[0], externalTriggerPin};
        end
    end

    // counter clears when it reaches the stable threshold; glitches restart it [R21]
    assign pinStable = (stableCnt_ff >= `ARC_STABLE_CLKS - 3'h1);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stableCnt_ff <= 3'h0;
            pinLevel_ff <= 1'b1;
        end else if (pinSync_ff[1] == pinLevel_ff) begin
            stableCnt_ff <= 3'h0;
        end else if (pinStable) begin
            stableCnt_ff <= 3'h0;
            pinLevel_ff <= pinSync_ff[1]; // accepted level change [R15] [R21]
        end else begin
            stableCnt_ff <= stableCnt_ff + 3'h1;
        end
    end
    // filtered level must also have been stable before it flipped, so the
    // counter covers both the high and the low phase [R15]
    assign pinEdge = (pinSync_ff[1] != pinLevel_ff) && pinStable &&
        (pinSync_ff[1] == ctrl_ff[`ARC_BIT_EDGE]);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pwmPrev_ff <= 1'b0;
        end else begin
            pwmPrev_ff <= pwmTrigger;
        end
    end

    // reserved source codes start nothing [R16] [R14]
    always_comb begin
        hwTrig = 1'b0;
        if (ctrl_ff[`ARC_BIT_HWEN]) begin
            case (ctrl_ff[`ARC_SRC_HI:`ARC_SRC_LO])
                `ARC_SRC_PIN: hwTrig = pinEdge;
                `ARC_SRC_PWM: hwTrig = pwmTrigger && !pwmPrev_ff;
                default: hwTrig = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // control register; hardware clears start on completion [R10]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_ff <= `ARC_CTRL_RESET; // bias 0x800 [R9]
        end else begin
            if (wrAcc && apbReq.paddr == `ARC_OFS_CTRL) begin
                ctrl_ff <= apbReq.pwdata & `ARC_CTRL_MASK; // reserved bits dropped [R22]
            end
            if (hwTrig) begin
                ctrl_ff[`ARC_BIT_START] <= 1'b1; // [R14] [R10]
            end
            if (convIn.done && state_ff != ARC_IDLE) begin
                ctrl_ff[`ARC_BIT_START] <= 1'b0; // [R10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // conversion sequencing: start pulse out, wait for done [R11]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= ARC_IDLE;
            convStart_ff <= 1'b0;
        end else begin
            convStart_ff <= 1'b0;
            case (state_ff)
                ARC_IDLE: begin
                    if (ctrl_ff[`ARC_BIT_START] && ctrl_ff[`ARC_BIT_PWR]) begin
                        state_ff <= ARC_BUSY;
                        convStart_ff <= 1'b1; // [R11]
                    end
                end
                ARC_BUSY: begin
                    if (convIn.done) begin
                        state_ff <= ARC_WAIT;
                    end else if (!ctrl_ff[`ARC_BIT_START] || !ctrl_ff[`ARC_BIT_PWR]) begin
                        state_ff <= ARC_IDLE; // cleared start stops it [R11] [R19]
                    end
                end
                ARC_WAIT: begin
                    // one cycle so the cleared start is seen before rearming
                    state_ff <= ARC_IDLE;
                end
                default: state_ff <= ARC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // result storage: direct register or fifo [R13]
    assign fifoWr = convIn.done && (state_ff == ARC_BUSY) && fifoOn && count_ff != `ARC_FIFO_FULL;
    assign fifoRd = (rdResult || fifoPop) && fifoOn && count_ff != 5'h00;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            direct_ff <= 12'h000;
        end else if (convIn.done && state_ff == ARC_BUSY && !fifoOn) begin
            direct_ff <= convIn.sample; // [R4]
        end
    end

    // flags live only with the fifo off; set wins over read-clear [R1] [R2] [R3]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            valid_ff <= 1'b0;
            ovr_ff <= 1'b0;
        end else if (fifoOn) begin
            valid_ff <= 1'b0; // [R3]
            ovr_ff <= 1'b0;
        end else if (convIn.done && state_ff == ARC_BUSY) begin
            valid_ff <= 1'b1; // [R1]
            ovr_ff <= ovr_ff || (valid_ff && !rdResult); // [R2]
        end else if (rdResult) begin
            valid_ff <= 1'b0; // [R1]
            ovr_ff <= 1'b0; // [R2]
        end
    end

    // memory holds no reset; pointers do
    always_ff @(posedge mclk) begin
        if (fifoWr) begin
            fifoMem_ff[wrPtr_ff] <= convIn.sample;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !fifoOn) begin
            wrPtr_ff <= 4'h0;
            rdPtr_ff <= 4'h0;
            count_ff <= 5'h00;
        end else begin
            if (fifoWr) begin
                wrPtr_ff <= wrPtr_ff + 4'h1;
            end
            if (fifoRd) begin
                rdPtr_ff <= rdPtr_ff + 4'h1;
            end
            if (fifoWr && !fifoRd) begin
                count_ff <= count_ff + 5'h01;
            end else if (fifoRd && !fifoWr) begin
                count_ff <= count_ff - 5'h01;
            end
        end
    end

    // dma threshold select: half full or full [R12]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dma_ff <= 1'b0;
        end else if (ctrl_ff[`ARC_BIT_FULLSEL]) begin
            dma_ff <= fifoOn && (count_ff == `ARC_FIFO_FULL); // [R12]
        end else begin
            dma_ff <= fifoOn && (count_ff >= `ARC_FIFO_HALF); // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////
    // result formatting from the selected path [R4] [R5] [R6] [R7] [R8]
    assign rawSample = fifoOn ? fifoMem_ff[rdPtr_ff] : direct_ff; // [R4]
    assign diff = {1'b0, rawSample} - {1'b0, ctrl_ff[`ARC_BIAS_HI:`ARC_BIAS_LO]}; // [R9]
    always_comb begin
        case ({ctrl_ff[`ARC_BIT_SUB], ctrl_ff[`ARC_BIT_LSH]})
            2'h0: formatted = {4'h0, rawSample}; // [R4] [R7]
            2'h1: formatted = {rawSample, 4'h0}; // [R6] [R7]
            2'h2: formatted = {{4{diff[12]}}, diff[11:0]}; // [R5] [R8]
            2'h3: formatted = {diff[12], diff[11:0], 3'h0}; // [R6] [R8]
            default: formatted = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // conversion-end flag; set beats software clear [R20]
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            endFlag_ff <= 1'b0;
        end else if (convIn.done && state_ff == ARC_BUSY) begin
            endFlag_ff <= 1'b1; // [R20]
        end else if (wrAcc && apbReq.paddr == `ARC_OFS_STATUS &&
            apbReq.pwdata[`ARC_BIT_ENDF]) begin
            endFlag_ff <= 1'b0; // write one to clear [R20]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= endFlag_ff && ctrl_ff[`ARC_BIT_IEN]; // [R18]
        end
    end

    ////////////////////////////////////////////////////////////////
    // read mux; reserved bits zero [R22]
    always_comb begin
        nxt_prdata = 32'h00000000;
        case (apbReq.paddr)
            `ARC_OFS_RESULT: begin
                nxt_prdata[15:0] = formatted;
                nxt_prdata[`ARC_BIT_VALID] = valid_ff;
                nxt_prdata[`ARC_BIT_OVR] = ovr_ff;
            end
            `ARC_OFS_CTRL: nxt_prdata = ctrl_ff;
            `ARC_OFS_STATUS: nxt_prdata[`ARC_BIT_ENDF] = endFlag_ff;
            default: nxt_prdata = 32'h00000000;
        endcase
    end

    // unmapped addresses answer with pslverr
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= (wrAcc || rdAcc);
            pslverr_ff <= (wrAcc || rdAcc) && apbReq.paddr != `ARC_OFS_RESULT &&
                apbReq.paddr != `ARC_OFS_CTRL && apbReq.paddr != `ARC_OFS_STATUS;
            if (rdAcc) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign convStart = convStart_ff;
    assign converterPowerEnable = ctrl_ff[`ARC_BIT_PWR]; // [R19]
    assign conversionIrq = irq_ff;
    assign dmaReq = dma_ff;
endmodule

// ==== arc_control_asserts.sv ====
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module arc_control_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire arc_pkg::arc_apb_req_t apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic convStart,
    input wire logic converterPowerEnable,
    input wire logic conversionIrq,
    input wire logic dmaReq
);
    import arc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic ien_ff;
    logic fifo_ff;
    wire taken = apbReq.psel & apbReq.penable & !pready;
    wire ctlAddr = apbReq.paddr == 12'h020;
    wire ctlWr = pready & apbReq.pwrite & ctlAddr;
    // shadow lags the design by one edge, so the checks below stay loose
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ien_ff <= 1'b0;
            fifo_ff <= 1'b0;
        end else if (ctlWr) begin
            ien_ff <= apbReq.pwdata[1];
            fifo_ff <= apbReq.pwdata[9];
        end
    end
    a_ready_wait: assert property (taken |=> pready) else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    a_unmapped_err: assert property (pready |-> pslverr == !(apbReq.paddr inside {
        12'h000, 12'h020, 12'h030})) else $error("bad slverr");
    a_unmapped_zero: assert property (pready && pslverr && !apbReq.pwrite |->
        prdata == 32'h00000000) else $error("unmapped data");
    a_power_bit: assert property (ctlWr |-> converterPowerEnable == apbReq.pwdata[0])
        else $error("power bit");
    a_start_write: assert property (taken && apbReq.pwrite && ctlAddr &&
        apbReq.pwdata[11] && apbReq.pwdata[0] |-> ##[1:3] convStart) else $error("no start");
    a_start_pulse: assert property (convStart |=> !convStart) else $error("start held");
    a_start_power: assert property (convStart |-> converterPowerEnable)
        else $error("start unpowered");
    a_irq_enable: assert property (conversionIrq |-> ien_ff) else $error("irq masked");
    a_dma_fifo: assert property (dmaReq |-> fifo_ff) else $error("dma no fifo");
endmodule
bind arc_control arc_control_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .convStart(convStart),
    .converterPowerEnable(converterPowerEnable), .conversionIrq(conversionIrq),
    .dmaReq(dmaReq));

// ==== arc_conv_model.sv ====
// behavioural analog converter answering start pulses
`timescale 1ns/1ps
module arc_conv_model #(
    parameter int LAT = 6
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic convStart,
    input wire logic converterPowerEnable,
    input wire logic [11:0] sampleVal,
    output arc_pkg::arc_conv_t convOut
);
    import arc_pkg::*;
    logic [3:0] left_ff;
    // sample bus toggles outside done so a stale value never looks valid
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            left_ff <= 4'h0;
            convOut <= '0;
        end else begin
            convOut.done <= left_ff == 4'h1;
            convOut.sample <= (left_ff == 4'h1) ? sampleVal : ~convOut.sample;
            if (!converterPowerEnable) begin
                left_ff <= 4'h0;
            end else if (convStart) begin
                left_ff <= 4'(LAT);
            end else if (left_ff != 4'h0) begin
                left_ff <= left_ff - 4'h1;
            end
        end
    end
endmodule

// ==== arc_tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb;
    import arc_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, pin = 1'b1, pwm = 1'b0, pop = 1'b0, er;
    logic pready, pslverr, convStart, pwrEn, irq, dma;
    logic [31:0] prdata, rd, seed = 32'hB1021106;
    logic [11:0] smp = 12'h000, b, s;
    logic [11:0] q[$];
    arc_apb_req_t req = '0;
    arc_conv_t convIn;
    int errorCnt = 0, checksDone = 0, cyc = 0, starts = 0, s0;
    always #50 mclk = ~mclk;
    arc_control dut (.mclk(mclk), .rst_n(rst_n), .apbReq(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .convIn(convIn), .externalTriggerPin(pin),
        .pwmTrigger(pwm), .fifoPop(pop), .convStart(convStart),
        .converterPowerEnable(pwrEn), .conversionIrq(irq), .dmaReq(dma));
    arc_conv_model cvm (.mclk(mclk), .rst_n(rst_n), .convStart(convStart),
        .converterPowerEnable(pwrEn), .sampleVal(smp), .convOut(convIn));
    ////////////////////////////////////////////////////////////
    function logic [11:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[11:0];
    endfunction
    // m[1] is bias subtraction, m[0] is left shift
    function logic [15:0] fmt(input logic [11:0] v, input logic [11:0] bs, input logic [1:0] m);
        logic [12:0] d;
        d = {1'b0, v} - {1'b0, bs};
        case (m)
            2'h0: fmt = {4'h0, v};
            2'h1: fmt = {v, 4'h0};
            2'h2: fmt = {{4{d[12]}}, d[11:0]};
            default: fmt = {d[12], d[11:0], 3'h0};
        endcase
    endfunction
    task chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_bit(input string n, input logic e, input logic g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask
    task printVerdict();
        $display("checks %0d mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one apb transfer, held until pready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 30);
        // a transfer that never answers counts against the run
        if (pready !== 1'b1) begin
            errorCnt++;
            $display("Error pready expected 1 seen %b", pready);
        end
        rd = prdata;
        er = pslverr;
        req <= '0;
    endtask
    task conv(input logic [31:0] c);
        int n;
        s = rnd();
        smp <= s;
        q.push_back(s);
        apb(1'b1, 12'h020, c | 32'h00000801);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (convIn.done !== 1'b1 && n < 40);
        if (convIn.done !== 1'b1) begin
            errorCnt++;
            $display("Error conversion done expected 1 seen %b", convIn.done);
        end
        repeat (2) @(posedge mclk);
    endtask
    // cycle count for the hang limit and a tally of start pulses
    always @(posedge mclk) begin
        cyc++;
        if (convStart === 1'b1) starts++;
        if (cyc == 20000) begin
            errorCnt++;
            printVerdict();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h020, 0);
        chk_word("ctrl reset", 32'h08000000, rd);
        apb(1'b0, 12'h000, 0);
        chk_word("result reset", 32'h0, rd);
        apb(1'b0, 12'h010, 0);
        chk_word("unmapped data", 32'h0, rd);
        chk_bit("unmapped err", 1'b1, er);
        apb(1'b1, 12'h020, 32'hFFFFF7FE);
        apb(1'b0, 12'h020, 0);
        chk_word("ctrl reserved", 32'h0FFF3772, rd);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            b = rnd();
            conv({4'h0, b, 2'h0, m[1:0], 12'h002});
            chk_bit("irq", 1'b1, irq);
            apb(1'b0, 12'h000, 0);
            chk_word("fmt", {16'h0002, fmt(s, b, m[1:0])}, rd);
            apb(1'b0, 12'h000, 0);
            chk_bit("valid clear", 1'b0, rd[17]);
            apb(1'b1, 12'h030, 32'h1);
            repeat (2) @(posedge mclk);
            chk_bit("irq clear", 1'b0, irq);
        end
        $display("test formats done");
        conv(32'h08000001);
        conv(32'h08000001);
        chk_bit("irq masked", 1'b0, irq);
        apb(1'b0, 12'h000, 0);
        chk_word("overrun", {14'h0, 2'h3, 4'h0, s}, rd);
        apb(1'b1, 12'h030, 32'h1);
        $display("test overrun done");
        q.delete();
        repeat (8) conv(32'h08000201);
        chk_bit("dma half", 1'b1, dma);
        apb(1'b1, 12'h020, 32'h08000601);
        repeat (2) @(posedge mclk);
        chk_bit("dma full", 1'b0, dma);
        apb(1'b0, 12'h000, 0);
        chk_word("fifo head", {20'h0, q[0]}, rd);
        pop <= 1'b1;
        @(posedge mclk);
        pop <= 1'b0;
        apb(1'b0, 12'h000, 0);
        chk_word("fifo popped", {20'h0, q[2]}, rd);
        apb(1'b1, 12'h020, 32'h08000001);
        $display("test fifo done");
        apb(1'b1, 12'h020, 32'h08000101);
        s0 = starts;
        pin <= 1'b0;
        repeat (2) @(posedge mclk);
        pin <= 1'b1;
        repeat (10) @(posedge mclk);
        chk_word("glitch", s0, starts);
        pin <= 1'b0;
        repeat (12) @(posedge mclk);
        chk_word("pin fall", s0 + 1, starts);
        pin <= 1'b1;
        repeat (12) @(posedge mclk);
        chk_word("pin rise", s0 + 1, starts);
        apb(1'b1, 12'h020, 32'h08000001);
        apb(1'b1, 12'h020, 32'h08000131);
        s0 = starts;
        pwm <= 1'b1;
        repeat (4) @(posedge mclk);
        chk_word("pwm start", s0 + 1, starts);
        pwm <= 1'b0;
        repeat (12) @(posedge mclk);
        apb(1'b1, 12'h020, 32'h08000031);
        pwm <= 1'b1;
        repeat (4) @(posedge mclk);
        pwm <= 1'b0;
        chk_word("pwm off", s0 + 1, starts);
        // reserved source code must start nothing even with a pwm edge
        apb(1'b1, 12'h020, 32'h08000011);
        apb(1'b1, 12'h020, 32'h08000111);
        pwm <= 1'b1;
        repeat (4) @(posedge mclk);
        pwm <= 1'b0;
        chk_word("reserved src", s0 + 1, starts);
        // rising polarity: the falling edge is ignored, the rising one starts
        apb(1'b1, 12'h020, 32'h08000001);
        apb(1'b1, 12'h020, 32'h08000141);
        pin <= 1'b0;
        repeat (12) @(posedge mclk);
        chk_word("rise only", s0 + 1, starts);
        pin <= 1'b1;
        repeat (12) @(posedge mclk);
        chk_word("pin rise start", s0 + 2, starts);
        $display("test triggers done");
        // reset in mid-run brings the control word back to its default
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h020, 0);
        chk_word("ctrl rerun", 32'h08000000, rd);
        $display("test reset done");
        printVerdict();
    end
endmodule
